/* File: src/buck_seq_pkg.sv */
package buck_seq_pkg;

  // Switching cycles the soft-start node is held low in hiccup
  localparam int HICCUP_CYCLES = 4096;

  // Switching cycles at each pre-bias ramp step
  localparam int STEP0_PULSES = 32;
  localparam int STEP1_PULSES = 16;
  localparam int STEP2_PULSES = 8;

  // Current-sense blanking after low-side turn-on
  localparam int CLK_PERIOD_NS = 100;
  localparam int BLANK_TIME_NS = 160;
  localparam int BLANK_CYCLES  =
    (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Switching clock range set by the frequency_set_resistor
  localparam int SW_FREQ_MIN_KHZ = 250;
  localparam int SW_FREQ_MAX_KHZ = 1500;

  // Synchronous FET on-time as a fraction of steady state
  typedef enum logic [1:0] {
    STEP_25,
    STEP_50,
    STEP_75,
    STEP_FULL
  } ls_step_e;

  typedef enum {
    ST_OFF,
    ST_SOFT,
    ST_RUN,
    ST_HICCUP,
    ST_THERM,
    ST_SD
  } seq_state_e;

  // Qualified comparator results and timing inputs
  typedef struct packed {
    logic vcc_ok;
    logic en_ok;
    logic ss_low;
    logic ss_top;
    logic oc_below;
    logic therm;
    logic sw_clk;
    logic hs_pwm;
  } sense_s;

endpackage : buck_seq_pkg

/* File: src/sync2.sv */
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule : sync2

/* File: src/prebias_ramp.sv */
`timescale 1ns/1ps
module prebias_ramp
  import buck_seq_pkg::*;
#(
  parameter int S0 = STEP0_PULSES,
  parameter int S1 = STEP1_PULSES,
  parameter int S2 = STEP2_PULSES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic clear,
  input  wire logic run,
  input  wire logic sw_tick,
  // Step
  output ls_step_e  step
);

  localparam int CW = $clog2(S0 + 1);

  ls_step_e        step_q;
  logic [CW-1:0]   cnt_q;
  logic [CW-1:0]   limit;
  logic            step_end;

  assign limit    = (step_q == STEP_25) ? CW'(S0 - 1) :
                    (step_q == STEP_50) ? CW'(S1 - 1) : CW'(S2 - 1);
  assign step_end = run && sw_tick && step_q != STEP_FULL &&
                    cnt_q == limit;

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      step_q <= STEP_25;
      cnt_q  <= '0;
    end else if (step_end) begin
      step_q <= ls_step_e'(step_q + 2'h1);
      cnt_q  <= '0;
    end else if (run && sw_tick && step_q != STEP_FULL) begin
      cnt_q  <= cnt_q + CW'(1);
    end
  end

  assign step = step_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_dwell0;
    step_q == STEP_25 && cnt_q == CW'(S0 - 1) && run && sw_tick && !clear
      |=> step_q == STEP_50;
  endproperty
  a_dwell0: assert property (p_dwell0)
    else $error("Ramp left first step at wrong count");

endmodule : prebias_ramp

/* File: src/buck_startup_fault_sequencer.sv */
// Functional notes
// - Both drivers off while supply or enable is below threshold.
// - Power-on-ready needs supply and enable; only it starts soft start.
// - Sync FET stays off until first control FET pulse.
// - Sync FET on-time widens 25, 50, 75, 100 percent.
// - Pulses per ramp step fixed: 32, 16, then 8.
// - Soft start ends when ramp reaches its top level.
// - Over-current detection stays armed during soft start.
// - Sequencer paced by resistor-set switching clock.
// - Enable below turn-off level tristates both drivers.
// - Soft-start node pulled low in run state stops switching until released; ignored during soft start.
// - Over-current when sense node below ground while low side on.
// - Over-current sets latched flag and enters hiccup.
// - Hiccup discharges soft start, counts cycles, clears latch, restarts.
// - Hiccup retries repeat without limit while overload persists.
// - Current sensing blanked a fixed delay after low side turns on.
// - Thermal trip turns off both FETs and discharges soft start.
// - Thermal restart automatic with fresh soft start once trip clears.
`timescale 1ns/1ps
module buck_startup_fault_sequencer
  import buck_seq_pkg::*;
#(
  parameter int HICCUP_LEN = HICCUP_CYCLES,
  parameter int BLANK_LEN  = BLANK_CYCLES
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Comparator results and timing, asynchronous
  input  wire sense_s sense_raw,
  // Driver permits
  output logic        hs_drv_en,
  output logic        ls_drv_en,
  output logic        drv_oe,
  // Soft start and status
  output logic        ss_discharge,
  output logic        por_ready,
  output logic        overcurrent_trip_latch,
  output ls_step_e    ls_step,
  output logic        thermal_off
);

  localparam int HW = $clog2(HICCUP_LEN + 1);
  localparam int BW = $clog2(BLANK_LEN + 1);

  sense_s          s;
  seq_state_e      st_q;
  seq_state_e      st_d;
  logic            sw_prev_q;
  logic            hs_prev_q;
  logic            first_pulse_q;
  logic [HW-1:0]   hic_cnt_q;
  logic [BW-1:0]   blank_cnt_q;
  logic            hs_q;
  logic            ls_q;
  logic            oe_q;
  logic            ss_dis_q;
  logic            por_q;
  logic            oc_latch_q;
  logic            therm_q;
  ls_step_e        step_q;
  ls_step_e        ramp_step;

  // Every sense input is a pin, so all pass the synchroniser
  sync2 #(
    .W ($bits(sense_s))
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (sense_raw),
    .q     (s)
  );

  wire por      = s.vcc_ok && s.en_ok;
  wire sw_tick  = s.sw_clk && !sw_prev_q;
  wire hs_rise  = s.hs_pwm && !hs_prev_q;
  wire running  = st_q == ST_SOFT || st_q == ST_RUN;
  wire run_d    = st_d == ST_SOFT || st_d == ST_RUN;
  wire oc_sample = ls_q && blank_cnt_q == BW'(BLANK_LEN);
  wire oc_event = running && oc_sample && s.oc_below;
  wire hic_done = st_q == ST_HICCUP && sw_tick &&
                  hic_cnt_q == HW'(HICCUP_LEN - 1);

  // Analog ramp shapes on-time; this only sets the step
  wire hs_d     = run_d && s.hs_pwm;
  wire ls_d     = run_d && first_pulse_q && !s.hs_pwm;
  wire ss_dis_d = !(run_d || st_d == ST_SD);
  // Set wins over clear if both land together
  // Thermal exit is a fresh start, so a stale latch must not survive it
  wire latch_d  = oc_event ||
                  (oc_latch_q && !hic_done && por && !s.therm);

  always_comb begin
    st_d = st_q;
    if (!por) begin
      st_d = ST_OFF;
    end else if (s.therm) begin
      st_d = ST_THERM;
    end else begin
      case (st_q)
        ST_OFF: begin
          st_d = ST_SOFT;
        end
        ST_SOFT: begin
          if (oc_event) begin
            st_d = ST_HICCUP;
          end else if (s.ss_top) begin
            st_d = ST_RUN;
          end
        end
        ST_RUN: begin
          if (oc_event) begin
            st_d = ST_HICCUP;
          end else if (s.ss_low) begin
            st_d = ST_SD;
          end
        end
        ST_HICCUP: begin
          if (hic_done) begin
            st_d = ST_SOFT;
          end
        end
        ST_THERM: begin
          st_d = ST_SOFT;
        end
        ST_SD: begin
          if (!s.ss_low) begin
            st_d = ST_SOFT;
          end
        end
        default: begin
          st_d = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q      <= ST_OFF;
      sw_prev_q <= 1'b0;
      hs_prev_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      sw_prev_q <= s.sw_clk;
      hs_prev_q <= s.hs_pwm;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !running) begin
      first_pulse_q <= 1'b0;
    end else if (hs_rise) begin
      first_pulse_q <= 1'b1;
    end
  end

  // Counts switching cycles, not system clocks
  always_ff @(posedge clk) begin
    if (!rst_n || st_q != ST_HICCUP) begin
      hic_cnt_q <= '0;
    end else if (sw_tick) begin
      hic_cnt_q <= hic_cnt_q + HW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !ls_q) begin
      blank_cnt_q <= '0;
    end else if (blank_cnt_q != BW'(BLANK_LEN)) begin
      blank_cnt_q <= blank_cnt_q + BW'(1);
    end
  end

  prebias_ramp u_ramp (
    .clk     (clk),
    .rst_n   (rst_n),
    .clear   (!running),
    .run     (first_pulse_q),
    .sw_tick (sw_tick),
    .step    (ramp_step)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hs_q       <= 1'b0;
      ls_q       <= 1'b0;
      oe_q       <= 1'b0;
      ss_dis_q   <= 1'b1;
      por_q      <= 1'b0;
      oc_latch_q <= 1'b0;
      therm_q    <= 1'b0;
      step_q     <= STEP_25;
    end else begin
      hs_q       <= hs_d;
      ls_q       <= ls_d;
      oe_q       <= s.en_ok;
      ss_dis_q   <= ss_dis_d;
      por_q      <= por;
      oc_latch_q <= latch_d;
      therm_q    <= s.therm;
      step_q     <= ramp_step;
    end
  end

  assign hs_drv_en              = hs_q;
  assign ls_drv_en              = ls_q;
  assign drv_oe                 = oe_q;
  assign ss_discharge           = ss_dis_q;
  assign por_ready              = por_q;
  assign overcurrent_trip_latch = oc_latch_q;
  assign ls_step                = step_q;
  assign thermal_off            = therm_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_lockout;
    !por |=> !hs_drv_en && !ls_drv_en;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("Driver on during lockout");

  property p_por_start;
    st_q == ST_OFF && por && !s.therm |=> st_q == ST_SOFT;
  endproperty
  a_por_start: assert property (p_por_start)
    else $error("Ready did not launch soft start");

  property p_first_pulse;
    !first_pulse_q |=> !ls_drv_en;
  endproperty
  a_first_pulse: assert property (p_first_pulse)
    else $error("Sync FET on before first pulse");

  property p_step_order;
    $changed(ls_step) |->
      ls_step == STEP_25 || 2'(ls_step - $past(ls_step)) == 2'h1;
  endproperty
  a_step_order: assert property (p_step_order)
    else $error("Ramp step skipped");

  property p_ss_top;
    st_q == ST_SOFT && por && !s.therm && !oc_event && s.ss_top
      |=> st_q == ST_RUN;
  endproperty
  a_ss_top: assert property (p_ss_top)
    else $error("Soft start did not end at top");

  property p_oc_hiccup;
    oc_event && por && !s.therm
      |=> st_q == ST_HICCUP && overcurrent_trip_latch ##1 ss_discharge;
  endproperty
  a_oc_hiccup: assert property (p_oc_hiccup)
    else $error("Over-current did not enter hiccup");

  property p_hiccup_done;
    hic_done && por && !s.therm
      |=> st_q == ST_SOFT && !overcurrent_trip_latch;
  endproperty
  a_hiccup_done: assert property (p_hiccup_done)
    else $error("Hiccup end did not restart");

  property p_hiccup_hold;
    st_q == ST_HICCUP |-> ss_discharge && hic_cnt_q < HW'(HICCUP_LEN);
  endproperty
  a_hiccup_hold: assert property (p_hiccup_hold)
    else $error("Hiccup hold broken");

  property p_tristate;
    !s.en_ok |=> !drv_oe;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("Drivers not tristated");

  property p_blank;
    oc_sample |-> $past(ls_q) && $past(ls_q, 2);
  endproperty
  a_blank: assert property (p_blank)
    else $error("Sense sampled inside blanking");

  property p_thermal;
    s.therm && por |=> !hs_drv_en && !ls_drv_en && ss_discharge;
  endproperty
  a_thermal: assert property (p_thermal)
    else $error("Thermal trip left FETs on");

  property p_therm_restart;
    st_q == ST_THERM && !s.therm && por |=> st_q == ST_SOFT;
  endproperty
  a_therm_restart: assert property (p_therm_restart)
    else $error("No restart after thermal clear");

  property p_shutdown;
    st_q == ST_SD |-> !hs_drv_en && !ls_drv_en;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("Switching during soft-start shutdown");

  property p_por_clear;
    !por |=> ##1 hic_cnt_q == '0 && !first_pulse_q;
  endproperty
  a_por_clear: assert property (p_por_clear)
    else $error("Counters kept after ready loss");

  c_run:    cover property (st_q == ST_SOFT ##1 st_q == ST_RUN);
  c_hiccup: cover property (st_q == ST_HICCUP ##1 st_q == ST_SOFT);
  c_therm:  cover property (st_q == ST_THERM ##1 st_q == ST_SOFT);
  c_full:   cover property (ls_step == STEP_FULL && ls_drv_en);

endmodule : buck_startup_fault_sequencer

/* File: verif/sense_model.sv */
`timescale 1ns/1ps
module sense_model
  import buck_seq_pkg::*;
#(
  parameter int SWP    = 8,
  parameter int SS_TOP = 80
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Scenario controls
  input  wire logic vcc_up,
  input  wire logic en_up,
  input  wire logic overload,
  input  wire logic hot,
  input  wire logic ss_pull,
  // Sequencer outputs
  input  wire logic ls_drv_en,
  input  wire logic ss_discharge,
  // Comparator results
  output sense_s    sense
);
  int ph_q;
  int lvl_q;

  // Soft-start node charges once per switching cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_q  <= 0;
      lvl_q <= 0;
    end else begin
      ph_q <= (ph_q == SWP - 1) ? 0 : ph_q + 1;
      if (ss_discharge || ss_pull) begin
        lvl_q <= 0;
      end else if (ph_q == 0 && lvl_q < SS_TOP) begin
        lvl_q <= lvl_q + 1;
      end
    end
  end

  always_comb begin
    sense.vcc_ok   = vcc_up;
    sense.en_ok    = en_up;
    sense.ss_low   = ss_pull;
    sense.ss_top   = (lvl_q >= SS_TOP);
    // Sense node only dips while the low side conducts
    sense.oc_below = overload && ls_drv_en;
    sense.therm    = hot;
    sense.sw_clk   = (ph_q < SWP / 2);
    sense.hs_pwm   = (ph_q == 1 || ph_q == 2);
  end
endmodule : sense_model

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import buck_seq_pkg::*;
  localparam int SWP = 8;
  localparam int HL  = 8;
  localparam int VCC = 0, EN = 1, OVL = 2, HOT = 3, PULL = 4;
  localparam int POR = 0, HS = 1, LAT = 2, THM = 3, TOP = 4;

  logic     clk = 1'b0;
  logic     rst_n = 1'b0;
  logic     vcc_up = 1'b0, en_up = 1'b0, overload = 1'b0;
  logic     hot = 1'b0, ss_pull = 1'b0;
  sense_s   sense;
  logic     hs_drv_en, ls_drv_en, drv_oe, ss_discharge, por_ready;
  logic     overcurrent_trip_latch, thermal_off;
  ls_step_e ls_step;
  logic     first_seen = 1'b0, early_ls = 1'b0;
  int       failures = 0, num_checks = 0;

  initial begin
    forever #50 clk = ~clk;
  end

  buck_startup_fault_sequencer #(.HICCUP_LEN(HL), .BLANK_LEN(2)) u_dut (
    .clk(clk), .rst_n(rst_n), .sense_raw(sense), .hs_drv_en(hs_drv_en),
    .ls_drv_en(ls_drv_en), .drv_oe(drv_oe), .ss_discharge(ss_discharge),
    .por_ready(por_ready), .overcurrent_trip_latch(overcurrent_trip_latch),
    .ls_step(ls_step), .thermal_off(thermal_off));

  sense_model #(.SWP(SWP), .SS_TOP(80)) u_far (
    .clk(clk), .rst_n(rst_n), .vcc_up(vcc_up), .en_up(en_up),
    .overload(overload), .hot(hot), .ss_pull(ss_pull),
    .ls_drv_en(ls_drv_en), .ss_discharge(ss_discharge), .sense(sense));

  // Low side seen before the first high-side pulse of a start
  always @(posedge clk) begin
    if (por_ready !== 1'b1 || ss_discharge === 1'b1) first_seen <= 1'b0;
    else if (hs_drv_en === 1'b1) first_seen <= 1'b1;
    else if (ls_drv_en === 1'b1 && !first_seen) early_ls <= 1'b1;
  end

  task automatic fail(input string msg);
    failures++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask : fail

  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) fail(msg);
  endtask : check

  task automatic set_in(input int k, input logic v);
    @(posedge clk);
    case (k)
      VCC: vcc_up <= v;
      EN: en_up <= v;
      OVL: overload <= v;
      HOT: hot <= v;
      default: ss_pull <= v;
    endcase
    #1;
  endtask : set_in

  function automatic logic obs(input int k);
    case (k)
      POR: return por_ready;
      HS: return hs_drv_en;
      LAT: return overcurrent_trip_latch;
      THM: return thermal_off;
      default: return sense.ss_top;
    endcase
  endfunction : obs

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : cyc

  // Bounded wait; n returns the cycles taken
  task automatic wait_for(input int k, input logic v, input int lim,
                          output int n);
    n = 0;
    while (obs(k) !== v && n < lim) begin
      cyc(1);
      n++;
    end
    check(obs(k) === v, "wait timed out");
  endtask : wait_for

  task automatic wait_step(input ls_step_e s, input int e);
    int n;
    n = 0;
    while (ls_step !== s && n < e + 20) begin
      cyc(1);
      n++;
    end
    check(ls_step === s && n >= e - 12 && n <= e + 12, "ramp step timing");
  endtask : wait_step

  // Counts cycles with either driver permitted
  task automatic quiet(input int c, output int cnt);
    cnt = 0;
    repeat (c) begin
      cyc(1);
      if (hs_drv_en !== 1'b0 || ls_drv_en !== 1'b0) cnt++;
    end
  endtask : quiet

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // Whole sequence needs under two thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    fail("watchdog expired");
    wrap_up();
  end

  initial begin
    int n;
    cyc(5);
    check(ss_discharge === 1'b1 && ls_step === STEP_25 && drv_oe === 1'b0
          && hs_drv_en === 1'b0 && por_ready === 1'b0, "reset values");
    @(posedge clk);
    rst_n <= 1'b1;
    set_in(VCC, 1'b1);
    set_in(EN, 1'b1);
    wait_for(POR, 1'b1, 8, n);
    cyc(2);
    check(ss_discharge === 1'b0 && drv_oe === 1'b1, "start");
    wait_for(HS, 1'b1, 40, n);
    wait_step(STEP_50, 32 * SWP);
    wait_step(STEP_75, 16 * SWP);
    wait_step(STEP_FULL, 8 * SWP);
    set_in(EN, 1'b0);
    cyc(6);
    check(drv_oe === 1'b0 && hs_drv_en === 1'b0 && ls_drv_en === 1'b0
          && por_ready === 1'b0, "enable off");
    check(ls_step === STEP_25, "ramp cleared");
    set_in(VCC, 1'b0);
    set_in(EN, 1'b1);
    quiet(4 * SWP, n);
    check(n == 0 && por_ready === 1'b0, "supply low");
    set_in(VCC, 1'b1);
    wait_for(POR, 1'b1, 8, n);
    wait_for(TOP, 1'b1, 1000, n);
    cyc(8);
    set_in(PULL, 1'b1);
    cyc(8);
    quiet(3 * SWP, n);
    check(n == 0, "switching while pulled low");
    set_in(PULL, 1'b0);
    wait_for(HS, 1'b1, 80, n);
    set_in(OVL, 1'b1);
    wait_for(LAT, 1'b1, 60, n);
    cyc(3);
    check(hs_drv_en === 1'b0 && ls_drv_en === 1'b0
          && ss_discharge === 1'b1, "hiccup");
    wait_for(LAT, 1'b0, 120, n);
    check(n >= HL * SWP - 19 && n <= HL * SWP + 13, "hiccup");
    wait_for(LAT, 1'b1, 100, n);
    set_in(HOT, 1'b1);
    set_in(OVL, 1'b0);
    wait_for(THM, 1'b1, 8, n);
    cyc(3);
    check(hs_drv_en === 1'b0 && ls_drv_en === 1'b0
          && ss_discharge === 1'b1, "thermal off");
    set_in(HOT, 1'b0);
    wait_for(THM, 1'b0, 8, n);
    cyc(3);
    check(ss_discharge === 1'b0 && ls_step === STEP_25, "re");
    check(overcurrent_trip_latch === 1'b0, "stale latch");
    wait_for(HS, 1'b1, 60, n);
    check(early_ls === 1'b0, "low side before first pulse");
    wrap_up();
  end
endmodule : tb_top
